// file: bench/sld_checker.sv
// Purpose: port assertions of the led drive core
// Assumes: one clock, synchronous high reset
// Notes: pins reach the drivers four edges late
`timescale 1ns/1ps
`default_nettype none
module sld_checker import sld_pkg::*; (
   input wire logic       clk,       // clock
   input wire logic       rst,       // reset
   input wire sld_req_t   req,       // register request
   input wire logic [2:0] color_en,  // enable pins
   input wire sld_sense_t sense,     // comparators
   input wire logic [2:0] drv_on,    // driver enables
   input wire logic [9:0] drv_level, // active level
   input wire logic       standby,   // standby
   input wire logic       fault_oe,  // fault pin drive
   input wire logic [7:0] nvm_addr,  // store address
   input wire logic       nvm_we     // store write
);
   // ---
   // assertions
   // ---
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence store_walk;
      nvm_addr == 8'h00 ##1 (nvm_we && nvm_addr == 8'h01);
   endsequence
   one_drive_a: assert property ($onehot0(drv_on))
      else $error("two drivers on");
   grant_hold_a: assert property ((|(drv_on & color_en))[*4] |=> drv_on == $past(drv_on))
      else $error("grant moved while enable high");
   reset_state_a: assert property ($fell(rst) |-> standby && drv_on == 3'h0 && !fault_oe)
      else $error("bad state after reset");
   boot_reload_a: assert property ($fell(rst) |-> ##[20:30] nvm_addr == 8'h16)
      else $error("startup reload missing");
   store_standby_a: assert property (nvm_we |-> standby)
      else $error("store outside standby");
   store_order_a: assert property ($rose(nvm_we) |-> store_walk)
      else $error("store walk wrong");
   idle_level_a: assert property (drv_on == 3'h0 |-> drv_level == 10'h000)
      else $error("level without driver");
   drive_awake_a: assert property (drv_on != 3'h0 |-> !standby)
      else $error("driving in standby");
   fault_read_a: assert property ((sense == '0)[*4] ##0 (req.rd && req.addr == A_FAULT && $stable(drv_on))
      |=> !fault_oe)
      else $error("fault pin kept after read");
endmodule
bind sld_core sld_checker sld_checker_i (.clk(clk), .rst(rst), .req(req), .color_en(color_en),
   .sense(sense), .drv_on(drv_on), .drv_level(drv_level), .standby(standby), .fault_oe(fault_oe),
   .nvm_addr(nvm_addr), .nvm_we(nvm_we));
`default_nettype wire

// file: bench/sld_nvm_model.sv
// Purpose: nonvolatile store beside the core
// Assumes: combinational read, write on strobe
// Notes: cells past the map read as erased
`timescale 1ns/1ps
`default_nettype none
module sld_nvm_model import sld_pkg::*; (
   input  wire logic       clk,   // clock
   input  wire logic [7:0] addr,  // byte address
   input  wire logic [7:0] wdata, // write data
   input  wire logic       we,    // write strobe
   output logic      [7:0] rdata  // read data
);
   // ---
   // storage
   // ---
   logic [7:0] mem [NREG];
   initial for (int i = 0; i < NREG; i++) mem[i] = REG_RST[i];
   always @(posedge clk) if (we && addr < NREG) mem[addr] <= wdata;
   assign rdata = (addr < NREG) ? mem[addr] : 8'hFF;
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench of the led drive core
// Assumes: short store, pwm and timeout counts
// Notes: pwm pin toggles at half duty once, otherwise it rests low
`timescale 1ns/1ps
`default_nettype none
module tb_top import sld_pkg::*;;
   logic clk = 1'b0, rst = 1'b1, pwm_in = 1'b0, standby, fault_oe, nvm_we;
   sld_req_t req = '0;
   sld_sense_t sense = '0;
   logic [2:0] color_en = 3'h0, drv_on;
   logic [7:0] reg_rdata, nvm_addr, nvm_wdata, nvm_rdata;
   logic [9:0] drv_level;
   int fail_count = 0, cmp_count = 0, cyc = 0;
   always #5 clk = ~clk;
   sld_core #(.PROG_CYC(50), .PWM_TO(20), .TO_STEP(30)) sld_core_i (.clk(clk), .rst(rst), .req(req),
      .reg_rdata(reg_rdata), .color_en(color_en), .pwm_in(pwm_in), .sense(sense), .drv_on(drv_on),
      .drv_level(drv_level), .standby(standby), .fault_oe(fault_oe), .nvm_addr(nvm_addr),
      .nvm_wdata(nvm_wdata), .nvm_we(nvm_we), .nvm_rdata(nvm_rdata));
   sld_nvm_model sld_nvm_model_i (.clk(clk), .addr(nvm_addr), .wdata(nvm_wdata), .we(nvm_we),
      .rdata(nvm_rdata));
   // ---
   // helpers
   // ---
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("BAD %0t run hung", $time);
         results();
      end
   end
   task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '0;
      chk(10'(reg_rdata), 10'(exp), what);
   endtask
   task automatic hold_en(input logic [2:0] e, input int n);
      color_en = e;
      repeat (n) @(negedge clk);
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_reset();
      rd(A_FAULT, 8'h00, "fault after start");
      rd(A_FADER, REG_RST[A_FADER], "restored dimmer");
      rd(8'h50, 8'h00, "unmapped read");
      $display("reset test done");
   endtask
   task automatic t_arb();
      hold_en(3'b111, 8);
      chk(10'(drv_on), 10'h001, "red first");
      hold_en(3'b110, 8);
      chk(10'(drv_on), 10'h002, "green next");
      hold_en(3'b111, 8);
      chk(10'(drv_on), 10'h002, "green held");
      hold_en(3'b101, 8);
      chk(10'(drv_on), 10'h001, "red over blue");
      hold_en(3'b000, 8);
      $display("arbitration test done");
   endtask
   task automatic t_level();
      int b;
      for (int c = 0; c < 4; c++) begin
         b = (c > 1) ? 2 : c;
         wr(A_BANK, 8'(c));
         hold_en(3'b001, 8);
         chk(drv_level, {REG_RST[2+6*b][1:0], REG_RST[1+6*b]}, "bank level");
         hold_en(3'b000, 4);
      end
      wr(A_BANK, 8'h00);
      wr(A_FADER, 8'h80);
      wr(A_CTRL, 8'h02);
      hold_en(3'b001, 8);
      chk(drv_level, 10'((32'h181 * 128) / 255), "dimmed level");
      hold_en(3'b000, 4);
      wr(A_CTRL, 8'h03);
      repeat (6) begin
         pwm_in = 1'b1;
         repeat (5) @(negedge clk);
         pwm_in = 1'b0;
         repeat (5) @(negedge clk);
      end
      hold_en(3'b001, 30);
      chk(drv_level, 10'((32'h181 * 128) / 255), "pwm duty level");
      hold_en(3'b000, 8);
      hold_en(3'b001, 8);
      chk(drv_level, 10'h000, "pwm source");
      hold_en(3'b000, 4);
      wr(A_CTRL, 8'h00);
      $display("level test done");
   endtask
   task automatic t_fault();
      sld_sense_t sv [4] = '{6'b110000, 6'b001000, 6'b000100, 6'b110100};
      logic [7:0] fl [4] = '{8'(1 << F_OPEN), 8'(1 << F_SHORT), 8'(1 << F_OCP), 8'(1 << F_OCP)};
      wr(A_FMASK, 8'(1 << F_SHORT));
      sense = 6'b000100;
      hold_en(3'b001, 12);
      sense = '0;
      hold_en(3'b001, 6);
      hold_en(3'b000, 8);
      rd(A_FAULT, 8'h00, "mid colour limit");
      for (int i = 0; i < 4; i++) begin
         hold_en(3'b001, 8);
         sense = sv[i];
         hold_en(3'b001, 4);
         hold_en(3'b000, 6);
         sense = '0;
         hold_en(3'b000, 4);
         chk(10'(fault_oe), 10'(|(fl[i] & ~8'(1 << F_SHORT))), "fault pin");
         rd(A_FAULT, fl[i], "fault flags");
         chk(10'(fault_oe), 10'h000, "pin released");
      end
      $display("fault test done");
   endtask
   task automatic t_store();
      hold_en(3'b000, 40);
      chk(10'(standby), 10'h001, "idle standby");
      wr(A_FADER, 8'h5A);
      wr(A_NVCMD, CMD_PREPARE);
      wr(A_NVCMD, CMD_WRITE);
      repeat (23 + 50 + 5) @(negedge clk);
      rd(A_NVCMD, 8'h80, "store done");
      chk(10'(sld_nvm_model_i.mem[A_FADER]), 10'h05A, "stored byte");
      wr(A_FADER, 8'h11);
      wr(A_NVCMD, CMD_PREPARE);
      wr(A_NVCMD, CMD_RELOAD);
      repeat (30) @(negedge clk);
      rd(A_FADER, 8'h5A, "reloaded byte");
      $display("store test done");
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (30) @(negedge clk);
      t_reset();
      t_arb();
      t_level();
      t_fault();
      t_store();
      results();
   end
endmodule
`default_nettype wire

// file: hdl/sld_arbiter.sv
// Purpose : one-hot colour grant with hold and fixed red-green-blue priority
// Assumes : enables already synchronised to clk
// Notes   : grant only moves after the held colour's enable is released
`timescale 1ns/1ps
`default_nettype none
module sld_arbiter import sld_pkg::*; (
   input  wire logic       clk,      // system clock
   input  wire logic       rst,      // synchronous reset
   input  wire logic [2:0] en_s,     // synced enables, bit0 red, bit1 green, bit2 blue
   output logic      [2:0] grant     // one-hot granted colour
);
   logic [2:0] grant_r;
   logic [2:0] grant_nxt;
   wire        hold = |(grant_r & en_s);

   // red wins, then green, then blue
   assign grant_nxt = hold      ? grant_r :                      // RULE1
                      en_s[0]   ? 3'h1 :                         // RULE2
                      en_s[1]   ? 3'h2 :
                      en_s[2]   ? 3'h4 : 3'h0;

   always_ff @(posedge clk) begin
      if (rst) grant_r <= 3'h0;
      else     grant_r <= grant_nxt;                             // RULE25
   end

   assign grant = grant_r;
endmodule
`default_nettype wire

// file: hdl/sld_core.sv
// Purpose : control core of a three channel sequential led driver
// Assumes : serial engine delivers decoded byte writes/reads on clk; nonvolatile
//           store reads combinationally from nvm_addr and writes on nvm_we
// Notes   : currents are given in setting codes, code 0 being the current floor
//
// Overview of operation
// [RULE1] only one colour drives; a new enable waits until the active one drops
// [RULE2] among pending enables red wins, then green, then blue
// [RULE3] serial accesses hit working registers; all but fault and command are storable
// [RULE4] after reset the stored values are copied into the working registers
// [RULE5] prepare then reload written to command register reloads working registers
// [RULE6] prepare then write written to command register stores working registers
// [RULE7] completion flag sets once storing finishes, about 200 ms
// [RULE8] the host stores only while the device is in standby
// [RULE9] each colour has a 10-bit setting per bank, low byte plus two high bits
// [RULE10] bank code 00 bank0, 01 bank1, 10 and 11 bank2
// [RULE11] dimmer and pwm bits choose no scaling, dimmer register or pwm input
// [RULE12] pwm source gives factor equal to measured high duty
// [RULE13] dimmer source gives factor equal to dimmer value over 255
// [RULE14] highest setting scales by factor, the others keep their ratio to it
// [RULE15] scaled currents span the floor up to the programmed setting
// [RULE16] pwm change applies at next enable rise only if older than 300 us
// [RULE17] every fault sets its flag and pulls fault low unless masked
// [RULE18] reading the fault register clears flags and releases the fault pin
// [RULE19] at colour end, open flags with output at max, no current, no overcurrent
// [RULE20] at colour end, short flags with output below threshold
// [RULE21] overcurrent flags only when the limit is active at colour end
// [RULE22] thermal and low supply force standby; low supply reloads stored values
// [RULE23] host reads the fault register after each shutdown to standby step
// [RULE24] normal returns to standby after all enables low for the timeout
// [RULE25] enables are synchronised and arbitrated once per clock
`timescale 1ns/1ps
`default_nettype none
module sld_core import sld_pkg::*; #(
   parameter int unsigned PROG_CYC = PROG_CYCLES,     // store duration in cycles
   parameter int unsigned PWM_TO   = PWM_TO_CYCLES,   // pwm settle time in cycles
   parameter int unsigned TO_STEP  = TO_STEP_CYCLES   // standby timeout step in cycles
) (
   input  wire logic       clk,          // system clock 100 MHz
   input  wire logic       rst,          // synchronous reset, high
   input  wire sld_req_t   req,          // register write/read strobe, address, data
   output logic      [7:0] reg_rdata,    // read data, valid the cycle after rd
   input  wire logic [2:0] color_en,     // colour enable pins, red green blue
   input  wire logic       pwm_in,       // brightness pin
   input  wire sld_sense_t sense,        // converter and protection comparators
   output logic      [2:0] drv_on,       // one-hot driver enable
   output logic      [9:0] drv_level,    // scaled current code of the active driver
   output logic            standby,      // device in standby
   output logic            fault_oe,     // fault pin pulled low while high
   output logic      [7:0] nvm_addr,     // nonvolatile byte address
   output logic      [7:0] nvm_wdata,    // nonvolatile write data
   output logic            nvm_we,       // nonvolatile write strobe
   input  wire logic [7:0] nvm_rdata     // nonvolatile read data of nvm_addr
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int unsigned NPIN = 10;
   wire  [NPIN-1:0] pin_raw = {sense, pwm_in, color_en};
   logic [NPIN-1:0] meta_r, pin_s;

   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge clk) begin
         if (rst) begin
            meta_r[i] <= 1'b0;
            pin_s[i]  <= 1'b0;
         end else begin
            meta_r[i] <= pin_raw[i];
            pin_s[i]  <= meta_r[i];                    // RULE25
         end
      end
   end

   wire [2:0]  en_s   = pin_s[2:0];
   wire        pwm_s  = pin_s[3];
   sld_sense_t sns_s;
   assign sns_s = sld_sense_t'(pin_s[9:4]);

   // ----------------------------------------------------------------
   // working registers and decode
   // ----------------------------------------------------------------
   logic [7:0] regs_r [NREG];
   logic [4:0] fault_r;
   logic       armed_r, done_r;
   sld_nv_t    nv_r;
   logic [7:0] rdata_r;

   wire wr_hit  = req.wr && req.addr <= A_LAST && nv_r != NV_RELOAD;   // RULE3
   wire cmd_wr  = req.wr && req.addr == A_NVCMD;
   wire flt_rd  = req.rd && req.addr == A_FAULT;
   wire [7:0] ctrl  = regs_r[A_CTRL[4:0]];
   wire [7:0] fmask = regs_r[A_FMASK[4:0]];

   // setting of colour c in the selected bank
   function automatic logic [9:0] iset_of(input logic [1:0] c, input logic [1:0] bank);
      logic [1:0] b;
      logic [4:0] lo;
      b  = (bank == 2'b00) ? 2'd0 : (bank == 2'b01) ? 2'd1 : 2'd2;         // RULE10
      lo = 5'(A_LEVEL0) + 5'(b) * 5'd6 + 5'(c) * 5'd2;
      return {regs_r[lo + 5'd1][1:0], regs_r[lo]};                          // RULE9
   endfunction

   wire [1:0] bank = regs_r[A_BANK[4:0]][1:0];
   wire [9:0] iset [3];
   for (genvar c = 0; c < 3; c++) begin : g_iset
      assign iset[c] = iset_of(2'(c), bank);
   end

   wire [7:0] rd_mux = (req.addr <= A_LAST) ? regs_r[req.addr[4:0]] :
                       (req.addr == A_FAULT) ? {3'h0, fault_r} :
                       (req.addr == A_NVCMD) ? {done_r, 4'h0, armed_r, 2'h0} : 8'h00;

   // ----------------------------------------------------------------
   // nonvolatile store sequencer
   // ----------------------------------------------------------------
   logic [7:0]  nv_addr_r, nv_wdata_r;
   logic        nv_we_r;
   logic [31:0] wait_r;
   logic        standby_r, uv_last_r;

   wire uv_rise   = sns_s.low_supply_trip & ~uv_last_r;
   wire go_reload = armed_r && cmd_wr && req.wdata == CMD_RELOAD;           // RULE5
   wire go_prog   = armed_r && cmd_wr && req.wdata == CMD_WRITE && standby_r; // RULE8
   wire nv_last   = nv_addr_r == A_LAST;

   always_ff @(posedge clk) begin
      if (rst) begin
         nv_r       <= NV_RELOAD;                                   // RULE4
         nv_addr_r  <= 8'h00;
         nv_wdata_r <= 8'h00;
         nv_we_r    <= 1'b0;
         wait_r     <= 32'h0;
         armed_r    <= 1'b0;
         done_r     <= 1'b0;
         uv_last_r  <= 1'b0;
      end else begin
         uv_last_r <= sns_s.low_supply_trip;
         nv_we_r   <= 1'b0;
         if (cmd_wr)
            armed_r <= req.wdata == CMD_PREPARE;
         case (nv_r)
            NV_IDLE: begin
               nv_addr_r <= 8'h00;
               if (go_reload || uv_rise) begin
                  nv_r <= NV_RELOAD;                                // RULE22
               end else if (go_prog) begin
                  nv_r       <= NV_PROG;                            // RULE6
                  done_r     <= 1'b0;
                  nv_we_r    <= 1'b1;
                  nv_wdata_r <= regs_r[0];
               end
            end
            NV_RELOAD: begin
               nv_addr_r <= nv_last ? 8'h00 : nv_addr_r + 8'h01;
               if (nv_last) nv_r <= NV_IDLE;
            end
            NV_PROG: begin
               if (nv_last) begin
                  nv_r   <= NV_WAIT;
                  wait_r <= 32'h0;
               end else begin
                  nv_addr_r  <= nv_addr_r + 8'h01;
                  nv_wdata_r <= regs_r[5'(nv_addr_r + 8'h01)];
                  nv_we_r    <= 1'b1;
               end
            end
            NV_WAIT: begin
               wait_r <= wait_r + 32'h1;
               if (wait_r >= PROG_CYC - 1) begin
                  nv_r   <= NV_IDLE;
                  done_r <= 1'b1;                                   // RULE7
               end
            end
            default: nv_r <= NV_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // working register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int r = 0; r < NREG; r++) regs_r[r] <= REG_RST[r];
      end else if (nv_r == NV_RELOAD) begin
         regs_r[nv_addr_r[4:0]] <= nvm_rdata;                      // RULE5
      end else if (wr_hit) begin
         regs_r[req.addr[4:0]] <= req.wdata;                       // RULE3
      end
   end

   always_ff @(posedge clk) begin
      if (rst)          rdata_r <= 8'h00;
      else if (req.rd)  rdata_r <= rd_mux;
   end

   // ----------------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------------
   logic [31:0] quiet_r;
   wire         trip    = sns_s.thermal_trip | sns_s.low_supply_trip;
   wire [31:0]  to_lim  = 32'(TO_STEP) * 32'({30'h0, ctrl[CTRL_TO_LSB +: 2]} + 32'h1);

   always_ff @(posedge clk) begin
      if (rst) begin
         standby_r <= 1'b1;
         quiet_r   <= 32'h0;
      end else begin
         quiet_r <= (|en_s) ? 32'h0 : quiet_r + 32'h1;
         if (trip || go_prog || nv_r != NV_IDLE)
            standby_r <= 1'b1;                                      // RULE22
         else if (|en_s)
            standby_r <= 1'b0;
         else if (quiet_r >= to_lim - 32'h1)
            standby_r <= 1'b1;                                      // RULE24
      end
   end

   // ----------------------------------------------------------------
   // arbitration and brightness
   // ----------------------------------------------------------------
   logic [2:0] grant;
   logic [7:0] duty;

   sld_arbiter u_arb (
      .clk  (clk),
      .rst  (rst),
      .en_s (en_s),
      .grant(grant)
   );

   sld_pwm_meter #(.TO_CYC(PWM_TO)) u_pwm (
      .clk  (clk),
      .rst  (rst),
      .pwm_s(pwm_s),
      .duty (duty)
   );

   // a duty change must age before an enable rise may adopt it
   logic [7:0]  duty_last_r, duty_use_r;
   logic [31:0] age_r;
   logic [2:0]  en_last_r;
   wire         en_rise = |(en_s & ~en_last_r);
   wire         aged    = age_r >= PWM_TO;

   always_ff @(posedge clk) begin
      if (rst) begin
         duty_last_r <= BRC_FULL;
         duty_use_r  <= BRC_FULL;
         age_r       <= 32'h0;
         en_last_r   <= 3'h0;
      end else begin
         en_last_r   <= en_s;
         duty_last_r <= duty;
         if (duty != duty_last_r) age_r <= 32'h0;
         else if (!aged)          age_r <= age_r + 32'h1;
         if (en_rise && aged) duty_use_r <= duty_last_r;            // RULE16
      end
   end

   wire [7:0] brightness_factor = ctrl[CTRL_PWM] ? duty_use_r :                     // RULE11
                    ctrl[CTRL_MFE] ? regs_r[A_FADER[4:0]] :            // RULE13
                    BRC_FULL;

   // scaling every setting by the same factor keeps each ratio to the highest
   // one up to the truncation of the divide by 255, and avoids a divider by a variable setting
   wire [1:0]  sel_c   = grant[0] ? 2'd0 : grant[1] ? 2'd1 : 2'd2;
   wire [17:0] prod    = iset[sel_c] * brightness_factor;                           // RULE14
   wire [9:0]  lvl_nxt = 10'(prod / 18'd255);                         // RULE15

   logic [2:0] drv_on_r;
   logic [9:0] lvl_r;
   wire  [2:0] drv_nxt = (standby_r || trip || nv_r != NV_IDLE) ? 3'h0 : grant; // RULE1 RULE22

   always_ff @(posedge clk) begin
      if (rst) begin
         drv_on_r <= 3'h0;
         lvl_r    <= 10'h000;
      end else begin
         drv_on_r <= drv_nxt;
         lvl_r    <= (drv_nxt != 3'h0) ? lvl_nxt : 10'h000;
      end
   end

   // ----------------------------------------------------------------
   // fault flags and pin
   // ----------------------------------------------------------------
   wire       col_end = (drv_on_r != 3'h0) && (drv_nxt != drv_on_r);
   wire [4:0] ev;
   logic      fault_oe_r;

   assign ev[F_OCP]   = col_end & sns_s.pos_limit;                               // RULE21
   assign ev[F_TSD]   = sns_s.thermal_trip;
   assign ev[F_LOW_SUPPLY_TRIP]  = sns_s.low_supply_trip;
   assign ev[F_OPEN]  = col_end & sns_s.converter_output_max & sns_s.no_current & ~sns_s.pos_limit; // RULE19
   assign ev[F_SHORT] = col_end & sns_s.converter_output_low;                                // RULE20

   // a new event in the clearing read's cycle survives the clear
   wire [4:0] fault_nxt = (flt_rd ? 5'h00 : fault_r) | ev;            // RULE18

   always_ff @(posedge clk) begin
      if (rst) begin
         fault_r    <= 5'h00;
         fault_oe_r <= 1'b0;
      end else begin
         fault_r    <= fault_nxt;                                     // RULE17
         fault_oe_r <= |(fault_nxt & ~fmask[4:0]);                    // RULE17
      end
   end

   assign reg_rdata = rdata_r;
   assign drv_on    = drv_on_r;
   assign drv_level = lvl_r;
   assign standby   = standby_r;
   assign fault_oe  = fault_oe_r;
   assign nvm_addr  = nv_addr_r;
   assign nvm_wdata = nv_wdata_r;
   assign nvm_we    = nv_we_r;

endmodule
`default_nettype wire

// file: hdl/sld_pwm_meter.sv
// Purpose : measures high-time duty of the brightness input as an 8-bit fraction
// Assumes : input synchronised; period fits 16 bits of clk cycles
// Notes   : a flat input for the timeout reads as 0 or full scale
`timescale 1ns/1ps
`default_nettype none
module sld_pwm_meter import sld_pkg::*; #(
   parameter int unsigned TO_CYC = PWM_TO_CYCLES
) (
   input  wire logic       clk,      // system clock
   input  wire logic       rst,      // synchronous reset
   input  wire logic       pwm_s,    // synced brightness input
   output logic      [7:0] duty      // last measured duty, 255 = always high
);
   logic [15:0] hi_r, per_r, rem_r, div_per_r;
   logic [7:0]  q_r, duty_r;
   logic [3:0]  step_r;
   logic [31:0] idle_r;
   logic        last_r;

   wire rise = pwm_s & ~last_r;
   wire [16:0] rem2 = {rem_r, 1'b0};
   wire        ge   = rem2 >= {1'b0, div_per_r};

   always_ff @(posedge clk) begin
      if (rst) begin
         hi_r <= 16'h0; per_r <= 16'h0; rem_r <= 16'h0; div_per_r <= 16'h1;
         q_r <= 8'h0; duty_r <= BRC_FULL; step_r <= 4'h0; idle_r <= 32'h0; last_r <= 1'b0;
      end else begin
         last_r <= pwm_s;
         if (rise) begin
            // start a shift-subtract divide of high time by period
            rem_r     <= hi_r;
            div_per_r <= (per_r == 16'h0) ? 16'h1 : per_r;
            step_r    <= 4'h8;
            q_r       <= 8'h0;
            hi_r      <= 16'h1;
            per_r     <= 16'h1;
            idle_r    <= 32'h0;
         end else begin
            if (pwm_s && hi_r != 16'hFFFF) hi_r <= hi_r + 16'h1;
            if (per_r != 16'hFFFF) per_r <= per_r + 16'h1;
            if (idle_r < TO_CYC) idle_r <= idle_r + 32'h1;
            else duty_r <= pwm_s ? BRC_FULL : 8'h00;
         end
         if (step_r != 4'h0 && !rise) begin
            rem_r  <= ge ? 16'(rem2 - {1'b0, div_per_r}) : rem2[15:0];
            q_r    <= {q_r[6:0], ge};
            step_r <= step_r - 4'h1;
            if (step_r == 4'h1)
               duty_r <= (rem_r >= div_per_r) ? BRC_FULL : {q_r[6:0], ge};   // RULE12
         end
      end
   end

   assign duty = duty_r;
endmodule
`default_nettype wire

// file: pkg/sld_pkg.sv
// Purpose : shared constants and carriers of the sequential led drive control core
// Assumes : 100 MHz system clock, byte wide register port from the serial engine
// Notes   : register indices equal the serial register addresses
package sld_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int unsigned NREG         = 23;            // 0x00..0x16 are storable
   localparam logic [7:0]  A_BANK       = 8'h00;
   localparam logic [7:0]  A_LEVEL0     = 8'h01;         // first current byte, low/high pairs follow
   localparam logic [7:0]  A_FADER      = 8'h13;
   localparam logic [7:0]  A_CTRL       = 8'h14;
   localparam logic [7:0]  A_ILIMIT     = 8'h15;
   localparam logic [7:0]  A_FMASK      = 8'h16;
   localparam logic [7:0]  A_LAST       = 8'h16;
   localparam logic [7:0]  A_FAULT      = 8'h17;
   localparam logic [7:0]  A_NVCMD      = 8'h40;

   // control register fields
   localparam int unsigned CTRL_PWM     = 0;
   localparam int unsigned CTRL_MFE     = 1;
   localparam int unsigned CTRL_TO_LSB  = 2;

   // fault and mask bit positions
   localparam int unsigned F_OCP        = 0;
   localparam int unsigned F_TSD        = 1;
   localparam int unsigned F_LOW_SUPPLY_TRIP       = 2;
   localparam int unsigned F_OPEN       = 3;
   localparam int unsigned F_SHORT      = 4;

   // nonvolatile command register
   localparam logic [7:0]  CMD_PREPARE  = 8'h04;
   localparam logic [7:0]  CMD_RELOAD   = 8'h01;
   localparam logic [7:0]  CMD_WRITE    = 8'h02;
   localparam int unsigned CMD_DONE_BIT = 7;
   localparam int unsigned CMD_ARM_BIT  = 2;

   localparam logic [7:0] REG_RST [NREG] = '{
      8'h00, 8'h81, 8'h01, 8'h81, 8'h01, 8'h81, 8'h01, 8'hE7, 8'h00, 8'hE7, 8'h00, 8'hE7,
      8'h00, 8'h4D, 8'h00, 8'h4D, 8'h00, 8'h4D, 8'h00, 8'hFF, 8'h00, 8'h11, 8'h00};

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned PROG_MS       = 200;
   localparam int unsigned PROG_CYCLES   = PROG_MS * 1000 * CLK_MHZ;
   localparam int unsigned PWM_TO_US     = 300;
   localparam int unsigned PWM_TO_CYCLES = PWM_TO_US * CLK_MHZ;
   localparam int unsigned TO_STEP_US    = 1000;
   localparam int unsigned TO_STEP_CYCLES = TO_STEP_US * CLK_MHZ;
   localparam logic [7:0]  BRC_FULL      = 8'hFF;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sld_req_t;

   typedef struct packed {
      logic converter_output_max;
      logic no_current;
      logic converter_output_low;
      logic pos_limit;
      logic thermal_trip;
      logic low_supply_trip;
   } sld_sense_t;

   typedef enum logic [1:0] {NV_RELOAD, NV_IDLE, NV_PROG, NV_WAIT} sld_nv_t;

endpackage
